// File: rls_sequencer.sv
`timescale 1ns/1ps
// Function
// - Hold reset 66 oscillator cycles after start-up.
// - Crystal option stretches hold to 5000 cycles.
// - Allow 4 us oscillator start-up first.
// - Stop wake-up resets only CPU, watchdog, oscillator.
// - Power-on hold starts once supply passes threshold.
// - Stay in reset while reset pin held.
// - GPIO become inputs, pull-ups off, except shared pin.
// - Shared pin open-drain, driven low during reset.
// - CPU, peripherals idle; oscillators keep running.
// - Load control registers with reset values.
// - Fetch reset vector from 0002H and 0003H.
// - Clock from internal oscillator after system reset.
module rls_sequencer
   import rls_pkg::*;
#(
   parameter int unsigned HOLD_SHORT = rls_pkg::RLS_HOLD_SHORT,
   parameter int unsigned HOLD_XTAL = rls_pkg::RLS_HOLD_XTAL,
   parameter int unsigned OSC_START_CYC = rls_pkg::RLS_OSC_START_CYC
) (
   // Internal oscillator clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Reset sources and crystal option, asynchronous.
   input wire logic supply_above_por,
   input wire logic ext_reset_pin_n,
   input wire logic stop_wake,
   input wire logic xtal_option_en,
   // Shared reset pin, open drain.
   output logic shared_reset_pin_out,
   output logic shared_reset_pin_oe,
   // GPIO reset configuration.
   output logic [rls_pkg::RLS_GPIO_W-1:0] gpio_dir_out,
   output logic [rls_pkg::RLS_GPIO_W-1:0] gpio_pue,
   output logic gpio_port_reset,
   // Core and register control.
   output logic cpu_reset_n,
   output logic periph_idle,
   output logic ctrl_reg_load,
   output logic watchdog_control_reg_load,
   output logic oscillator_control_reg_load,
   output logic sysclk_sel_ipo,
   output logic osc_keep_running,
   // Reset vector fetch.
   output logic vec_fetch,
   output logic [15:0] vec_addr,
   input wire logic [7:0] vec_data,
   output logic [15:0] pc_load_val,
   output logic pc_load
);
   import rls_pkg::*;

   if (HOLD_SHORT < 1 || HOLD_XTAL < 1 || OSC_START_CYC < 1 ||
       HOLD_SHORT > (1 << RLS_CNT_W) || HOLD_XTAL > (1 << RLS_CNT_W) ||
       OSC_START_CYC > (1 << RLS_CNT_W)) begin : g_bad_count
      $error("rls_sequencer: count parameter out of range");
   end

   localparam logic [RLS_CNT_W-1:0] OSC_LD = RLS_CNT_W'(OSC_START_CYC - 1);
   localparam logic [RLS_CNT_W-1:0] SHORT_LD = RLS_CNT_W'(HOLD_SHORT - 1);
   localparam logic [RLS_CNT_W-1:0] XTAL_LD = RLS_CNT_W'(HOLD_XTAL - 1);

   logic supply_s;
   logic pin_n_s;
   logic wake_s;
   logic xtal_s;
   logic supply_seen_q;
   logic wake_prev_q;
   logic pin_prev_q;
   rls_state_t state_q;
   rls_src_t src_q;
   logic cnt_load;
   logic [RLS_CNT_W-1:0] cnt_val;
   logic cnt_done;
   logic [7:0] vec_lo_q;
   logic por_ev;
   logic pin_ev;
   logic wake_ev;

   rls_sync #(.W(4)) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in({supply_above_por, ext_reset_pin_n, stop_wake, xtal_option_en}),
      .sync_out({supply_s, pin_n_s, wake_s, xtal_s})
   );

   // The hold counter runs from the oscillator clock itself.
   rls_counter #(.W(RLS_CNT_W)) u_cnt (
      .clock(clock),
      .rst_n(rst_n),
      .load(cnt_load),
      .load_val(cnt_val),
      .done(cnt_done)
   );

   // Edge history for the reset sources.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         supply_seen_q <= 1'b0;
         wake_prev_q <= 1'b0;
         // Matches the synchroniser's reset value, so no false edge follows reset.
         pin_prev_q <= 1'b0;
      end else begin
         supply_seen_q <= supply_s;
         wake_prev_q <= wake_s;
         pin_prev_q <= pin_n_s;
      end
   end

   // A supply drop back under threshold restarts a power-on sequence.
   assign por_ev = !supply_s;
   assign pin_ev = pin_prev_q && !pin_n_s;
   assign wake_ev = wake_s && !wake_prev_q && (state_q == RLS_RUN);

   // Sequence control.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= RLS_IDLE;
         src_q <= RLS_SRC_POR;
      end else if (por_ev) begin
         state_q <= RLS_IDLE;
         src_q <= RLS_SRC_POR;
      end else if (pin_ev && state_q != RLS_IDLE) begin
         state_q <= RLS_OSC_WAIT;
         src_q <= RLS_SRC_PIN;
      end else if (wake_ev) begin
         state_q <= RLS_OSC_WAIT;
         src_q <= RLS_SRC_STOP;
      end else begin
         case (state_q)
            RLS_IDLE: begin
               if (supply_seen_q) begin
                  state_q <= RLS_OSC_WAIT;
               end
            end
            RLS_OSC_WAIT: begin
               if (cnt_done) begin
                  state_q <= RLS_HOLD;
               end
            end
            RLS_HOLD: begin
               if (cnt_done) begin
                  state_q <= pin_n_s ? RLS_VEC_LO : RLS_PIN_WAIT;
               end
            end
            RLS_PIN_WAIT: begin
               if (pin_n_s) begin
                  state_q <= RLS_VEC_LO;
               end
            end
            RLS_VEC_LO: begin
               state_q <= RLS_VEC_HI;
            end
            RLS_VEC_HI: begin
               state_q <= RLS_RUN;
            end
            RLS_RUN: begin
               state_q <= RLS_RUN;
            end
            default: begin
               state_q <= RLS_IDLE;
            end
         endcase
      end
   end

   // Counter loads on entry to the start-up wait and to the hold phase.
   always_comb begin
      cnt_load = 1'b0;
      cnt_val = OSC_LD;
      if (por_ev || pin_ev || wake_ev || (state_q == RLS_IDLE && supply_seen_q)) begin
         cnt_load = 1'b1;
         cnt_val = OSC_LD;
      end else if (state_q == RLS_OSC_WAIT && cnt_done) begin
         cnt_load = 1'b1;
         cnt_val = xtal_s ? XTAL_LD : SHORT_LD;
      end
   end

   // Reset outputs; all release on the oscillator clock.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cpu_reset_n <= 1'b0;
         periph_idle <= 1'b1;
         osc_keep_running <= 1'b1;
      end else begin
         cpu_reset_n <= (state_q == RLS_RUN);
         periph_idle <= (state_q != RLS_RUN);
         osc_keep_running <= 1'b1;
      end
   end

   // Register reset loads; stop wake-up touches only two registers.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg_load <= 1'b1;
         watchdog_control_reg_load <= 1'b1;
         oscillator_control_reg_load <= 1'b1;
         sysclk_sel_ipo <= 1'b1;
      end else begin
         ctrl_reg_load <= (state_q != RLS_RUN) && (src_q != RLS_SRC_STOP);
         watchdog_control_reg_load <= (state_q != RLS_RUN);
         oscillator_control_reg_load <= (state_q != RLS_RUN);
         // The clock select returns to the internal oscillator on any reset.
         sysclk_sel_ipo <= (state_q != RLS_RUN);
      end
   end

   // Port reset: GPIO to inputs without pull-ups, shared pin pulled low.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gpio_dir_out <= RLS_GPIO_DIR_RST;
         gpio_pue <= RLS_GPIO_PUE_RST;
         gpio_port_reset <= 1'b1;
         shared_reset_pin_out <= 1'b0;
         shared_reset_pin_oe <= 1'b1;
      end else begin
         gpio_dir_out <= RLS_GPIO_DIR_RST;
         gpio_pue <= RLS_GPIO_PUE_RST;
         gpio_port_reset <= (state_q != RLS_RUN) && (src_q != RLS_SRC_STOP);
         shared_reset_pin_out <= 1'b0;
         shared_reset_pin_oe <= (state_q != RLS_RUN) && (src_q != RLS_SRC_STOP);
      end
   end

   // Reset vector fetch, low address then high address.
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         vec_fetch <= 1'b0;
         vec_addr <= RLS_VEC_ADDR_LO;
         vec_lo_q <= 8'h00;
         pc_load_val <= 16'h0000;
         pc_load <= 1'b0;
      end else begin
         pc_load <= 1'b0;
         vec_fetch <= 1'b0;
         if (state_q == RLS_VEC_LO) begin
            vec_fetch <= 1'b1;
            vec_addr <= RLS_VEC_ADDR_HI;
            vec_lo_q <= vec_data;
         end else if (state_q == RLS_VEC_HI) begin
            pc_load_val <= {vec_lo_q, vec_data};
            pc_load <= !por_ev;
         end else if (state_q != RLS_RUN) begin
            vec_addr <= RLS_VEC_ADDR_LO;
            // The fetch starts one cycle after the cycle that leaves the hold phase or the pin wait, in RLS_VEC_LO.
            vec_fetch <= !por_ev && pin_n_s &&
                         ((state_q == RLS_PIN_WAIT) || (state_q == RLS_HOLD && cnt_done));
         end
      end
   end
endmodule

// File: rls_pkg.sv
package rls_pkg;
   // Hold counts in oscillator cycles.
   localparam int unsigned RLS_HOLD_SHORT = 66;
   localparam int unsigned RLS_HOLD_XTAL = 5000;
   // Oscillator start-up allowance, in nanoseconds, and the clock period.
   localparam int unsigned RLS_OSC_START_NS = 4000;
   localparam int unsigned RLS_CLK_PERIOD_NS = 4;
   localparam int unsigned RLS_OSC_START_CYC =
      (RLS_OSC_START_NS + RLS_CLK_PERIOD_NS - 1) / RLS_CLK_PERIOD_NS;
   localparam int unsigned RLS_CNT_W = 16;
   localparam logic [15:0] RLS_VEC_ADDR_LO = 16'h0002;
   localparam logic [15:0] RLS_VEC_ADDR_HI = 16'h0003;
   localparam int unsigned RLS_GPIO_W = 8;
   localparam logic [7:0] RLS_GPIO_DIR_RST = 8'h00;
   localparam logic [7:0] RLS_GPIO_PUE_RST = 8'h00;

   typedef enum logic [2:0] {
      RLS_IDLE = 3'b000,
      RLS_OSC_WAIT = 3'b001,
      RLS_HOLD = 3'b010,
      RLS_PIN_WAIT = 3'b011,
      RLS_VEC_LO = 3'b100,
      RLS_VEC_HI = 3'b101,
      RLS_RUN = 3'b110
   } rls_state_t;

   typedef enum logic [1:0] {
      RLS_SRC_NONE = 2'b00,
      RLS_SRC_POR = 2'b01,
      RLS_SRC_PIN = 2'b10,
      RLS_SRC_STOP = 2'b11
   } rls_src_t;
endpackage

// File: rls_sync.sv
`timescale 1ns/1ps
module rls_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Data.
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_out <= '0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule

// File: rls_counter.sv
`timescale 1ns/1ps
module rls_counter #(
   parameter int W = 16
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rst_n,
   // Control.
   input wire logic load,
   input wire logic [W-1:0] load_val,
   output logic done
);
   logic [W-1:0] cnt_q;

   if (W < 2) begin : g_bad_width
      $error("rls_counter: width must be at least 2");
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= load_val;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
   end

   // Done must not look at load: the sequencer derives load from done.
   assign done = (cnt_q == '0);
endmodule

// File: rls_monitor.sv
`timescale 1ns/1ps
module rls_monitor
   import rls_pkg::*;
(
   // Clock, reset and sources.
   input wire logic clock,
   input wire logic rst_n,
   input wire logic supply_above_por,
   input wire logic ext_reset_pin_n,
   input wire logic stop_wake,
   // Sequencer outputs and vector data.
   input wire logic shared_reset_pin_oe,
   input wire logic [7:0] gpio_dir_out,
   input wire logic [7:0] gpio_pue,
   input wire logic gpio_port_reset,
   input wire logic cpu_reset_n,
   input wire logic periph_idle,
   input wire logic ctrl_reg_load,
   input wire logic sysclk_sel_ipo,
   input wire logic vec_fetch,
   input wire logic [15:0] vec_addr,
   input wire logic [7:0] vec_data,
   input wire logic [15:0] pc_load_val,
   input wire logic pc_load
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_vec_order: assert property (
      vec_fetch && vec_addr == RLS_VEC_ADDR_LO |=> vec_fetch && vec_addr == RLS_VEC_ADDR_HI)
      else $error("bad vector order");
   a_vec_value: assert property (
      pc_load |-> pc_load_val == {$past(vec_data, 2), $past(vec_data)})
      else $error("bad vector value");
   a_run_follows: assert property (pc_load |=> cpu_reset_n)
      else $error("core not released");
   a_core_idle: assert property (!cpu_reset_n |-> periph_idle && sysclk_sel_ipo)
      else $error("core not idle in reset");
   a_gpio_safe: assert property (gpio_port_reset |-> shared_reset_pin_oe &&
      gpio_dir_out == RLS_GPIO_DIR_RST && gpio_pue == RLS_GPIO_PUE_RST)
      else $error("bad port reset state");
   a_pin_holds: assert property (
      !ext_reset_pin_n [*5] |-> !cpu_reset_n && gpio_port_reset)
      else $error("released with pin low");
   a_supply_holds: assert property (
      !supply_above_por [*5] |-> !cpu_reset_n && ctrl_reg_load && gpio_port_reset)
      else $error("released with supply low");
   a_wake_keeps: assert property (
      $fell(cpu_reset_n) && stop_wake && ext_reset_pin_n && supply_above_por
      |-> !ctrl_reg_load && !gpio_port_reset)
      else $error("wake reloaded registers");
endmodule
bind rls_sequencer rls_monitor monitor (.clock(clock), .rst_n(rst_n),
   .supply_above_por(supply_above_por), .ext_reset_pin_n(ext_reset_pin_n),
   .stop_wake(stop_wake), .shared_reset_pin_oe(shared_reset_pin_oe),
   .gpio_dir_out(gpio_dir_out), .gpio_pue(gpio_pue), .gpio_port_reset(gpio_port_reset),
   .cpu_reset_n(cpu_reset_n), .periph_idle(periph_idle), .ctrl_reg_load(ctrl_reg_load),
   .sysclk_sel_ipo(sysclk_sel_ipo), .vec_fetch(vec_fetch), .vec_addr(vec_addr),
   .vec_data(vec_data), .pc_load_val(pc_load_val), .pc_load(pc_load));

// File: rls_env_model.sv
`timescale 1ns/1ps
module rls_env_model
   import rls_pkg::*;
(
   // Scenario controls.
   input wire logic supply_on,
   input wire logic pin_press,
   input wire logic [15:0] vector,
   // Device side.
   input wire logic [15:0] vec_addr,
   output logic supply_above_por,
   output logic ext_reset_pin_n,
   output logic [7:0] vec_data
);
   assign supply_above_por = supply_on;
   assign ext_reset_pin_n = !pin_press;
   // Program memory holds the vector high byte first; other places read as noise.
   assign vec_data = (vec_addr == RLS_VEC_ADDR_LO) ? vector[15:8] :
      (vec_addr == RLS_VEC_ADDR_HI) ? vector[7:0] : ~vec_addr[7:0];
endmodule

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
   import rls_pkg::*;
   localparam int HS = 66;
   localparam int HX = 120;
   localparam int OS = 5;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic supply_on = 1'b0;
   logic pin_press = 1'b0;
   logic stop_wake = 1'b0;
   logic xtal_option_en = 1'b0;
   logic [15:0] vector = 16'h0000;
   logic [31:0] seed = 32'h0AD1F465;
   logic [15:0] exp_q[$];
   logic supply_above_por, ext_reset_pin_n, cpu_reset_n, ctrl_reg_load, pc_load;
   logic gpio_port_reset, wdt_load, osc_load;
   logic sh_out, sh_oe, osc_run;
   logic [7:0] vec_data;
   logic [15:0] vec_addr, pc_load_val;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   initial begin
      forever #2 clock = ~clock;
   end
   rls_env_model env (.supply_on(supply_on), .pin_press(pin_press), .vector(vector),
      .vec_addr(vec_addr), .supply_above_por(supply_above_por),
      .ext_reset_pin_n(ext_reset_pin_n), .vec_data(vec_data));
   rls_sequencer #(.HOLD_SHORT(HS), .HOLD_XTAL(HX), .OSC_START_CYC(OS)) dut (.clock(clock),
      .rst_n(rst_n), .supply_above_por(supply_above_por), .ext_reset_pin_n(ext_reset_pin_n),
      .stop_wake(stop_wake), .xtal_option_en(xtal_option_en), .shared_reset_pin_out(sh_out),
      .shared_reset_pin_oe(sh_oe), .gpio_dir_out(), .gpio_pue(),
      .gpio_port_reset(gpio_port_reset),
      .cpu_reset_n(cpu_reset_n), .periph_idle(), .ctrl_reg_load(ctrl_reg_load),
      .watchdog_control_reg_load(wdt_load), .oscillator_control_reg_load(osc_load),
      .sysclk_sel_ipo(), .osc_keep_running(osc_run), .vec_fetch(), .vec_addr(vec_addr),
      .vec_data(vec_data), .pc_load_val(pc_load_val), .pc_load(pc_load));
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Each armed sequence expects one vector load with a fresh random vector.
   task automatic arm;
      seed = xorshift(seed);
      vector = seed[15:0];
      exp_q.push_back(seed[15:0]);
   endtask
   task automatic wait_run(input int lo, input int hi);
      int n;
      n = 0;
      while (cpu_reset_n !== 1'b1 && n < 9000) begin
         @(negedge clock);
         n++;
      end
      chk(n >= lo && n <= hi, 1);
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         final_report();
      end
   end
   // Sampled on the falling edge, where the one-cycle load pulse has settled.
   always @(negedge clock) begin
      if (pc_load === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(pc_load_val, 32'hFFFFFFFF);
         end else begin
            chk(pc_load_val, exp_q.pop_front());
         end
      end
   end
   initial begin
      repeat (6) @(posedge clock);
      @(negedge clock);
      rst_n = 1'b1;
      repeat (10) @(negedge clock);
      chk({cpu_reset_n, ctrl_reg_load}, 2'b01);
      chk({sh_out, sh_oe, osc_run}, 3'b011);
      arm();
      supply_on = 1'b1;
      wait_run(OS + HS, OS + HS + 12);
      chk({sh_out, sh_oe, osc_run}, 3'b001);
      supply_on = 1'b0;
      xtal_option_en = 1'b1;
      repeat (8) @(negedge clock);
      arm();
      supply_on = 1'b1;
      wait_run(OS + HX, OS + HX + 12);
      xtal_option_en = 1'b0;
      pin_press = 1'b1;
      repeat (OS + HS + 20 + int'(seed[4:0])) @(negedge clock);
      chk(cpu_reset_n, 0);
      arm();
      pin_press = 1'b0;
      wait_run(1, 20);
      repeat (2 + int'(seed[3:0])) @(negedge clock);
      arm();
      stop_wake = 1'b1;
      for (int i = 0; i < 10 && cpu_reset_n === 1'b1; i++) @(negedge clock);
      chk({cpu_reset_n, ctrl_reg_load, gpio_port_reset, wdt_load, osc_load}, 5'h03);
      wait_run(OS + HS - 4, OS + HS + 12);
      stop_wake = 1'b0;
      rst_n = 1'b0;
      @(negedge clock);
      chk({cpu_reset_n, gpio_port_reset, vec_addr}, {2'b01, RLS_VEC_ADDR_LO});
      arm();
      rst_n = 1'b1;
      wait_run(OS + HS, OS + HS + 12);
      chk(exp_q.size(), 0);
      final_report();
   end
endmodule
